// ### core/pwr_seq_pkg.sv
// Shared constants and types of the ADC power-down sequencer.
package pwr_seq_pkg;

    localparam int unsigned CNT_W         = 4;
    localparam logic [3:0]  CNT_MAX       = 4'h000F;
    localparam logic [3:0]  WIN_LO_EDGE   = 4'h0002;
    localparam logic [3:0]  WIN_HI_EDGE   = 4'h000A;
    localparam logic [3:0]  CNT_RST       = 4'h0000;
    localparam logic [3:0]  CNT_FIRST     = 4'h0001;
    localparam int unsigned SYS_CLK_NS    = 50;
    localparam int unsigned PART_PWRUP_NS = 1000;
    localparam int unsigned PART_PWRUP_CYC =
        (PART_PWRUP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int unsigned FULL_PWRUP_NS_DEF = 10000;
    localparam int unsigned TMR_W         = 16;
    localparam logic [15:0] TMR_ZERO      = 16'h0000;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_PARTIAL,
        MODE_FULL
    } pwr_mode_t;

endpackage

// ### core/pwr_link_if.sv
// Carrier of the gray-coded edge count from the link domain.
`timescale 1ns/100ps
interface pwr_link_if;
    import pwr_seq_pkg::*;

    logic [CNT_W-1:0] cnt_gray;
    logic             frame_tog;
    logic             cnt_tog;

    modport counter (output cnt_gray, output frame_tog, output cnt_tog);
    modport ctrl    (input  cnt_gray, input  frame_tog, input  cnt_tog);
endinterface

// ### core/sclk_edge_counter.sv
// Falling-edge counter of the ADC serial clock, link domain.
`timescale 1ns/100ps
module sclk_edge_counter
    import pwr_seq_pkg::*;
(
    // Link side
    input  wire logic   sclk_in,
    input  wire logic   sel_n_in,
    input  wire logic   arst_n_in,
    // To control domain
    pwr_link_if.counter link
);

    logic             rst_s1_q;
    logic             rst_s2_q;
    logic             fresh_q;
    logic             fresh_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] gray_q;
    logic [CNT_W-1:0] gray_d;
    logic             fresh_rst_n;
    logic             frame_q;
    logic             frame_d;
    logic             tag_q;
    logic             tag_d;

    // Reset release on the link clock.
    always_ff @(negedge sclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    // A high select arms the restart even while the clock stands still.
    assign fresh_rst_n = rst_s2_q & ~sel_n_in;

    always_comb begin
        fresh_d = fresh_q;
        cnt_d   = cnt_q;
        frame_d = ~frame_q;
        tag_d   = tag_q;
        if (!sel_n_in) begin
            fresh_d = 1'b0;
            tag_d   = frame_q;
            if (fresh_q) begin
                cnt_d = CNT_FIRST;
            end else if (cnt_q != CNT_MAX) begin
                cnt_d = cnt_q + CNT_FIRST;
            end
        end
        gray_d = cnt_d ^ (cnt_d >> 1);
    end

    // Each select fall opens a new frame; a count is tagged with its frame.
    always_ff @(negedge sel_n_in or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            frame_q <= 1'b0;
        end else begin
            frame_q <= frame_d;
        end
    end

    always_ff @(negedge sclk_in or negedge fresh_rst_n) begin
        if (!fresh_rst_n) begin
            fresh_q <= 1'b1;
        end else begin
            fresh_q <= fresh_d;
        end
    end

    always_ff @(negedge sclk_in or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            cnt_q  <= CNT_RST;
            gray_q <= CNT_RST;
            tag_q  <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            gray_q <= gray_d;
            tag_q  <= tag_d;
        end
    end

    assign link.cnt_gray  = gray_q;
    assign link.frame_tog = frame_q;
    assign link.cnt_tog   = tag_q;

endmodule

// ### core/adc_power_down_sequencer.sv
// Power-state sequencer of the dual-output serial ADC.
`timescale 1ns/100ps
module adc_power_down_sequencer
    import pwr_seq_pkg::*;
#(
    parameter int unsigned FULL_PWRUP_NS = FULL_PWRUP_NS_DEF
)
(
    // System clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       arst_n_in,
    // Link from the controller
    input  wire logic       adc_serial_clock_in,
    input  wire logic       conv_select_n_in,
    // Power state
    output logic      [1:0] pwr_mode_out,
    output logic            analog_on_out,
    output logic            ref_on_out,
    output logic            pwr_ready_out,
    output logic            conv_data_oe_out
);

    localparam int unsigned FULL_PWRUP_CYC =
        (FULL_PWRUP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

    if (FULL_PWRUP_CYC < 1 || FULL_PWRUP_CYC >= (1 << TMR_W)) begin : g_chk
        $error("FULL_PWRUP_NS out of range for the power-up timer.");
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset release and link crossing.

    logic             rst_s1_q;
    logic             rst_n;
    logic             sel_s1_q;
    logic             sel_s2_q;
    logic             sel_s3_q;
    logic [CNT_W-1:0] cnt_s1_q;
    logic [CNT_W-1:0] cnt_s2_q;
    logic [CNT_W-1:0] cnt_bin;
    logic             sel_rise;
    logic             frame_s1_q;
    logic             frame_s2_q;
    logic             tag_s1_q;
    logic             tag_s2_q;
    logic             stale;

    pwr_link_if link_if ();

    sclk_edge_counter u_counter (
        .sclk_in   (adc_serial_clock_in),
        .sel_n_in  (conv_select_n_in),
        .arst_n_in (arst_n_in),
        .link      (link_if.counter)
    );

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sel_s1_q <= 1'b1;
            sel_s2_q <= 1'b1;
            sel_s3_q <= 1'b1;
            cnt_s1_q   <= CNT_RST;
            cnt_s2_q   <= CNT_RST;
            frame_s1_q <= 1'b0;
            frame_s2_q <= 1'b0;
            tag_s1_q   <= 1'b0;
            tag_s2_q   <= 1'b0;
        end else begin
            sel_s1_q   <= conv_select_n_in;
            sel_s2_q   <= sel_s1_q;
            sel_s3_q   <= sel_s2_q;
            cnt_s1_q   <= link_if.cnt_gray;
            cnt_s2_q   <= cnt_s1_q;
            frame_s1_q <= link_if.frame_tog;
            frame_s2_q <= frame_s1_q;
            tag_s1_q   <= link_if.cnt_tog;
            tag_s2_q   <= tag_s1_q;
        end
    end

    // A frame without any clock fall leaves an old count behind.
    assign stale = frame_s2_q != tag_s2_q;

    always_comb begin
        cnt_bin = cnt_s2_q;
        for (int i = CNT_W - 2; i >= 0; i--) begin
            cnt_bin[i] = cnt_bin[i+1] ^ cnt_s2_q[i];
        end
    end

    assign sel_rise = sel_s2_q & ~sel_s3_q;

    ////////////////////////////////////////////////////////////////////////
    // Mode decision on each select rise.

    pwr_mode_t        mode_q;
    pwr_mode_t        mode_d;
    logic             eval_q;
    logic             eval_d;
    logic [TMR_W-1:0] tmr_q;
    logic [TMR_W-1:0] tmr_d;
    logic             ready_q;
    logic             ready_d;
    logic             analog_q;
    logic             analog_d;
    logic             ref_q;
    logic             ref_d;
    logic             oe_q;
    logic             oe_d;
    logic             in_win;
    logic             early;

    assign early  = stale || (cnt_bin < WIN_LO_EDGE);
    assign in_win = !early && (cnt_bin < WIN_HI_EDGE);

    always_comb begin
        eval_d = sel_rise;
        mode_d = mode_q;
        tmr_d  = tmr_q;
        if (tmr_q != TMR_ZERO) begin
            tmr_d = tmr_q - 16'h0001;
        end
        if (eval_q) begin
            unique case (mode_q)
                MODE_NORMAL: begin
                    if (in_win) begin
                        mode_d = MODE_PARTIAL;
                    end
                end
                MODE_PARTIAL: begin
                    if (in_win) begin
                        mode_d = MODE_FULL;
                    end else if (!early) begin
                        mode_d = MODE_NORMAL;
                        tmr_d  = TMR_W'(PART_PWRUP_CYC);
                    end
                end
                MODE_FULL: begin
                    if (!early && !in_win) begin
                        mode_d = MODE_NORMAL;
                        tmr_d  = TMR_W'(FULL_PWRUP_CYC);
                    end
                end
                default: begin
                    mode_d = MODE_NORMAL;
                end
            endcase
        end
        // Early rises fall through with the mode unchanged.
        ready_d  = (mode_d == MODE_NORMAL) && (tmr_d == TMR_ZERO);
        analog_d = (mode_q == MODE_NORMAL) || !sel_s2_q;
        ref_d    = (mode_q != MODE_FULL) || !sel_s2_q;
        oe_d     = (mode_q == MODE_NORMAL) && !sel_s2_q;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            mode_q   <= MODE_NORMAL;
            eval_q   <= 1'b0;
            tmr_q    <= TMR_ZERO;
            ready_q  <= 1'b1;
            analog_q <= 1'b1;
            ref_q    <= 1'b1;
            oe_q     <= 1'b0;
        end else begin
            mode_q   <= mode_d;
            eval_q   <= eval_d;
            tmr_q    <= tmr_d;
            ready_q  <= ready_d;
            analog_q <= analog_d;
            ref_q    <= ref_d;
            oe_q     <= oe_d;
        end
    end

    assign pwr_mode_out     = mode_q;
    assign analog_on_out    = analog_q;
    assign ref_on_out       = ref_q;
    assign pwr_ready_out    = ready_q;
    assign conv_data_oe_out = oe_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    AST_PART_TO_FULL: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n)
        eval_q && mode_q == MODE_PARTIAL && in_win |=> mode_q == MODE_FULL)
        else $error("Partial window rise did not enter full power-down.");

    AST_WAKE: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n)
        eval_q && mode_q != MODE_NORMAL && !early && !in_win
        |=> mode_q == MODE_NORMAL && !pwr_ready_out)
        else $error("Dummy conversion did not wake the converter.");

    AST_ABANDON: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n)
        eval_q && mode_q != MODE_NORMAL && early
        |=> $stable(mode_q) && !analog_on_out)
        else $error("Early rise did not abandon the power-up.");

    AST_REF_OFF: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n)
        mode_q == MODE_FULL && sel_s2_q |=> !ref_on_out && !analog_on_out)
        else $error("Reference still on in full power-down.");

    AST_NORM_TO_PART: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n)
        eval_q && mode_q == MODE_NORMAL && in_win
        |=> mode_q == MODE_PARTIAL ##1 !conv_data_oe_out)
        else $error("Normal window rise did not enter partial power-down.");

    AST_GLITCH: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n)
        eval_q && mode_q == MODE_NORMAL && early |=> mode_q == MODE_NORMAL)
        else $error("Select glitch powered the converter down.");

    AST_PART_READY: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n)
        eval_q && mode_q == MODE_PARTIAL && !early && !in_win
        |=> !pwr_ready_out [*8] ##[12:14] pwr_ready_out)
        else $error("Wake from partial not ready after one microsecond.");

    AST_EVAL: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n)
        eval_q |-> $past(sel_s2_q) && !$past(sel_s3_q))
        else $error("Mode evaluated without a select rise.");

endmodule

// ### dv/adc_ctrl_model.sv
// Behavioural model of the controller driving select and serial clock.
`timescale 1ns/100ps
module adc_ctrl_model (
    // System timing
    input  wire logic sys_clk_in,
    // Link to the converter
    output logic      adc_serial_clock_out,
    output logic      conv_select_n_out
);
    ////////////////////////////////////////////////////////////////////
    initial begin
        adc_serial_clock_out = 1'b1;
        conv_select_n_out    = 1'b1;
    end
    // Lowers select just after a system clock edge.
    task automatic sel_low();
        @(posedge sys_clk_in);
        conv_select_n_out <= 1'b0;
    endtask
    // Raises select without sending the rest of the frame.
    task automatic sel_high();
        @(posedge sys_clk_in);
        conv_select_n_out <= 1'b1;
    endtask
    // Sends n falls of the 12 ns link clock, then stands still high.
    task automatic pulses(input int n);
        #3;
        repeat (n) begin
            #6 adc_serial_clock_out = 1'b0;
            #6 adc_serial_clock_out = 1'b1;
        end
    endtask
endmodule

// ### dv/adc_power_down_sequencer_tb.sv
// Self-checking bench of the ADC power-down sequencer.
`timescale 1ns/100ps
module adc_power_down_sequencer_tb;
    import pwr_seq_pkg::*;
    localparam int unsigned FULL_NS = 2000;
    logic       sys_clk_in;
    logic       arst_n_in;
    wire        sclk;
    wire        sel_n;
    logic [1:0] pwr_mode_out;
    logic       analog_on_out;
    logic       ref_on_out;
    logic       pwr_ready_out;
    logic       conv_data_oe_out;
    int         fail_count;
    int         checks;
    ////////////////////////////////////////////////////////////////////
    adc_power_down_sequencer #(.FULL_PWRUP_NS(FULL_NS))
        u_adc_power_down_sequencer (
        .sys_clk_in          (sys_clk_in),
        .arst_n_in           (arst_n_in),
        .adc_serial_clock_in (sclk),
        .conv_select_n_in    (sel_n),
        .pwr_mode_out        (pwr_mode_out),
        .analog_on_out       (analog_on_out),
        .ref_on_out          (ref_on_out),
        .pwr_ready_out       (pwr_ready_out),
        .conv_data_oe_out    (conv_data_oe_out)
    );
    adc_ctrl_model u_adc_ctrl_model (
        .sys_clk_in           (sys_clk_in),
        .adc_serial_clock_out (sclk),
        .conv_select_n_out    (sel_n)
    );
    ////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk_in = 1'b0;
        arst_n_in  <= 1'b0;
        fail_count = 0;
        checks     = 0;
    end
    always #25 sys_clk_in = ~sys_clk_in;
    ////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [4:0] seen,
                         input logic [4:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [4:0] st();
        return {pwr_mode_out, analog_on_out, ref_on_out, conv_data_oe_out};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    task automatic frame(input int falls);
        u_adc_ctrl_model.sel_low();
        u_adc_ctrl_model.pulses(falls);
        u_adc_ctrl_model.sel_high();
        cyc(8);
    endtask
    task automatic final_report();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check("state", st(), {MODE_NORMAL, 3'b110});
        check("ready", {4'h0, pwr_ready_out}, 5'h01);
        u_adc_ctrl_model.pulses(2);
        cyc(2);
    endtask
    task automatic t_glitch();
        u_adc_ctrl_model.sel_low();
        cyc(6);
        check("state", st(), {MODE_NORMAL, 3'b111});
        u_adc_ctrl_model.pulses(1);
        u_adc_ctrl_model.sel_high();
        cyc(8);
        check("state", st(), {MODE_NORMAL, 3'b110});
    endtask
    task automatic t_abandon();
        u_adc_ctrl_model.sel_low();
        cyc(6);
        check("state", st(), {MODE_PARTIAL, 3'b110});
        u_adc_ctrl_model.pulses(1);
        u_adc_ctrl_model.sel_high();
        cyc(8);
        check("state", st(), {MODE_PARTIAL, 3'b010});
    endtask
    task automatic t_full();
        frame(2);
        check("state", st(), {MODE_PARTIAL, 3'b010});
        t_abandon();
        frame(9);
        check("state", st(), {MODE_FULL, 3'b000});
        frame(5);
        check("state", st(), {MODE_FULL, 3'b000});
    endtask
    task automatic t_wake_full();
        u_adc_ctrl_model.sel_low();
        cyc(6);
        check("state", st(), {MODE_FULL, 3'b110});
        u_adc_ctrl_model.pulses(10);
        u_adc_ctrl_model.sel_high();
        cyc(8);
        check("state", st(), {MODE_NORMAL, 3'b110});
        cyc(22);
        check("ready", {4'h0, pwr_ready_out}, 5'h00);
        cyc(20);
        check("ready", {4'h0, pwr_ready_out}, 5'h01);
    endtask
    task automatic t_wake_part();
        frame(3);
        frame(14);
        check("state", st(), {MODE_NORMAL, 3'b110});
        check("ready", {4'h0, pwr_ready_out}, 5'h00);
        cyc(22);
        check("ready", {4'h0, pwr_ready_out}, 5'h01);
        frame(10);
        check("state", st(), {MODE_NORMAL, 3'b110});
        check("ready", {4'h0, pwr_ready_out}, 5'h01);
    endtask
    task automatic t_no_edge();
        frame(3);
        check("state", st(), {MODE_PARTIAL, 3'b010});
        frame(0);
        check("state", st(), {MODE_PARTIAL, 3'b010});
    endtask
    task automatic t_midreset();
        frame(4);
        arst_n_in <= 1'b0;
        cyc(3);
        check("state", st(), {MODE_NORMAL, 3'b110});
        arst_n_in <= 1'b1;
        cyc(4);
        t_reset();
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        cyc(6);
        arst_n_in <= 1'b1;
        cyc(4);
        t_reset();
        t_glitch();
        t_full();
        t_wake_full();
        t_wake_part();
        t_no_edge();
        t_midreset();
        final_report();
    end
    initial begin
        #400000;
        fail_count++;
        final_report();
    end
endmodule
